/* tp_scheme_map.svh */
// Constants for the teleprotection scheme logic
`ifndef TP_SCHEME_MAP_SVH
`define TP_SCHEME_MAP_SVH
`define CLK_PERIOD_NS     50
`define MS_NS             1000000
`define TICK_CYCLES       (`MS_NS / `CLK_PERIOD_NS)
`define TIMER_W           14
`define DEF_SEND_MS       14'h000a
`define DEF_TRIP_DLY_MS   14'h000a
`define DEF_START_DLY_MS  14'h000a
`define DEF_MIN_BLOCK_MS  14'h000a
`define DEF_PROLONG_MS    14'h000a
`endif

/* tp_scheme_pkg.sv */
// Types for the teleprotection scheme logic
package tp_scheme_pkg;
  typedef enum logic [2:0] {
    SCHEME_OFF          = 3'h0,
    PERMISSIVE_UNDERREACH_MODE = 3'h1,
    PERMISSIVE_OVERREACH_MODE  = 3'h2,
    DIR_COMPARISON_MODE = 3'h3,
    DIR_BLOCKING_MODE   = 3'h4,
    DIRECT_UNDERREACH_MODE     = 3'h5
  } scheme_type;

  typedef enum logic {
    QUAL_PICKUP    = 1'b0,
    QUAL_OVERREACH = 1'b1
  } qualifier_type;

  typedef struct packed {
    logic forward_start;
    logic backward_start;
    logic underreach_start;
    logic overreach_start;
    logic general_trip;
  } starts_type;

  typedef struct packed {
    logic [13:0] send_prolong;
    logic [13:0] trip_delay;
    logic [13:0] start_delay;
    logic [13:0] min_block;
    logic [13:0] block_prolong;
  } times_type;
endpackage

/* tp_ms_timer.sv */
// Millisecond timer: on-delay plus drop-off prolongation
`timescale 1ns/1ns
`include "tp_scheme_map.svh"
module tp_ms_timer
  import tp_scheme_pkg::*;
#(
  parameter int W = `TIMER_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         tick,
  // Control
  input  wire logic         src,
  input  wire logic [W-1:0] on_ms,
  input  wire logic [W-1:0] off_ms,
  // Result
  output logic              on_done,
  output logic              held
);
  logic [W-1:0] on_cnt_q;
  logic [W-1:0] off_cnt_q;
  wire          on_hit  = (on_cnt_q >= on_ms);
  wire          off_run = (off_cnt_q != '0);

  // Timers count whole ms ticks; the on-delay clears when the source ends, the drop-off then counts down
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      on_cnt_q  <= '0;
      off_cnt_q <= '0;
    end else begin
      if (!src)                on_cnt_q <= '0;
      else if (tick && !on_hit) on_cnt_q <= on_cnt_q + 1'b1;
      if (src)                 off_cnt_q <= off_ms;
      else if (tick && off_run) off_cnt_q <= off_cnt_q - 1'b1;
    end
  end

  assign on_done = src && on_hit;
  assign held    = src || off_run;
endmodule // tp_ms_timer

/* tp_scheme_top.sv */
// Teleprotection scheme logic: send and trip generation
`timescale 1ns/1ns
`include "tp_scheme_map.svh"
module tp_scheme_top
  import tp_scheme_pkg::*;
(
  // Clock and reset
  input  wire logic          CLK_SYS,
  input  wire logic          RESET_N,
  // Configuration
  input  wire scheme_type    SCHEME_SELECT,
  input  wire qualifier_type UNDERREACH_TRIP_QUALIFIER,
  input  wire times_type     TIMES,
  // Protection inputs (pins, synchronised)
  input  wire logic          BLOCK_IN,
  input  wire logic          CHANNEL_FAILURE_IN,
  input  wire logic          RECEIVE_A_IN,
  input  wire logic          RECEIVE_B_IN,
  input  wire starts_type    STARTS_IN,
  // Outputs
  output logic               TELEPROT_TRIP,
  output logic               SEND_OUT
);
  localparam int NSYNC = 9;
  localparam int TICKC = `TICK_CYCLES;

  // ------------------------------------------------------------
  // Input synchronisers: three stages, change taken when 2 and 3 agree
  // ------------------------------------------------------------
  wire  [NSYNC-1:0] raw = {BLOCK_IN, CHANNEL_FAILURE_IN, RECEIVE_A_IN, RECEIVE_B_IN, STARTS_IN};
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, in_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      in_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      in_q <= (s2_q & s3_q) | (in_q & (s2_q | s3_q));
    end
  end
  wire        blk_i   = in_q[8];
  wire        fail_i  = in_q[7];
  wire        rec_i   = in_q[6] | in_q[5];
  starts_type st;
  assign st = starts_type'(in_q[4:0]);

  // ------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------
  logic [15:0] div_q;
  logic        tick_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == 16'(TICKC - 1));
      div_q  <= (div_q == 16'(TICKC - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  wire off_m  = (SCHEME_SELECT == SCHEME_OFF);
  wire permissive_underreach_mode_m = (SCHEME_SELECT == PERMISSIVE_UNDERREACH_MODE);
  wire permissive_overreach_mode_m = (SCHEME_SELECT == PERMISSIVE_OVERREACH_MODE);
  wire dcmp_m = (SCHEME_SELECT == DIR_COMPARISON_MODE);
  wire dblk_m = (SCHEME_SELECT == DIR_BLOCKING_MODE);
  wire direct_underreach_mode_m = (SCHEME_SELECT == DIRECT_UNDERREACH_MODE);
  wire legal  = permissive_underreach_mode_m | permissive_overreach_mode_m | dcmp_m | dblk_m | direct_underreach_mode_m;
  wire kill   = blk_i | !legal;

  // ------------------------------------------------------------
  // Send generation
  // ------------------------------------------------------------
  wire send_src = (permissive_underreach_mode_m & st.underreach_start)
                | (permissive_overreach_mode_m & (st.overreach_start | st.general_trip))
                | (dcmp_m & (st.forward_start | st.general_trip))
                | (dblk_m & st.backward_start)
                | (direct_underreach_mode_m & st.underreach_start);
  wire send_held;
  tp_ms_timer u_send (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .tick    (tick_q),
    .src     (send_src),
    .on_ms   ('0),
    .off_ms  (TIMES.send_prolong),
    .on_done (),
    .held    (send_held)
  );

  // ------------------------------------------------------------
  // Received blocking with minimum time and prolongation
  // ------------------------------------------------------------
  wire rblk_src = dblk_m & rec_i & !fail_i;
  wire rblk_long;
  tp_ms_timer u_rmin (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .tick    (tick_q),
    .src     (rblk_src),
    .on_ms   (TIMES.min_block),
    .off_ms  ('0),
    .on_done (rblk_long),
    .held    ()
  );
  logic prolong_arm_q;
  logic [`TIMER_W-1:0] pro_cnt_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      prolong_arm_q <= 1'b0;
      pro_cnt_q     <= '0;
    end else begin
      prolong_arm_q <= rblk_long;
      if (rblk_long)
        pro_cnt_q <= TIMES.block_prolong;
      else if (!dblk_m || fail_i)
        pro_cnt_q <= '0;
      else if (tick_q && pro_cnt_q != '0)
        pro_cnt_q <= pro_cnt_q - 1'b1;
    end
  end
  wire blocked = rblk_src | (pro_cnt_q != '0);

  // ------------------------------------------------------------
  // Delayed forward start and permissive underreach trip delay
  // ------------------------------------------------------------
  wire fw_delayed;
  tp_ms_timer u_fwd (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .tick    (tick_q),
    .src     (dblk_m & st.forward_start),
    .on_ms   (TIMES.start_delay),
    .off_ms  ('0),
    .on_done (fw_delayed),
    .held    ()
  );
  wire started  = st.forward_start | st.backward_start | st.underreach_start | st.overreach_start;
  wire permissive_underreach_mode_qual = (UNDERREACH_TRIP_QUALIFIER == QUAL_PICKUP) ? started
                                                              : st.overreach_start;
  wire permissive_underreach_mode_cond = permissive_underreach_mode_m & rec_i & !fail_i & permissive_underreach_mode_qual;
  wire permissive_underreach_mode_done;
  tp_ms_timer u_permissive_underreach_mode (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .tick    (tick_q),
    .src     (permissive_underreach_mode_cond),
    .on_ms   (TIMES.trip_delay),
    .off_ms  ('0),
    .on_done (permissive_underreach_mode_done),
    .held    ()
  );

  // ------------------------------------------------------------
  // Trip generation and output registers
  // ------------------------------------------------------------
  wire trip_src = permissive_underreach_mode_done
                | (permissive_overreach_mode_m & rec_i & !fail_i & st.overreach_start)
                | (dcmp_m & rec_i & !fail_i & st.forward_start)
                | (dblk_m & fw_delayed & !blocked)
                | (direct_underreach_mode_m & rec_i);
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      TELEPROT_TRIP <= 1'b0;
      SEND_OUT      <= 1'b0;
    end else begin
      TELEPROT_TRIP <= trip_src & !kill;
      SEND_OUT      <= send_held & !kill;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_KILL_LOW: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    $past(kill) |-> !TELEPROT_TRIP && !SEND_OUT) else $error("output active while blocked or off");
  AST_OFF_SEND: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    $past(off_m) |-> !SEND_OUT) else $error("send while scheme off");
  AST_PERMISSIVE_UNDERREACH_MODE_SEND: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    permissive_underreach_mode_m && st.underreach_start && !kill |=> SEND_OUT) else $error("underreach send missing");
  AST_PERMISSIVE_OVERREACH_MODE_SEND: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    permissive_overreach_mode_m && st.general_trip && !kill |=> SEND_OUT) else $error("overreach send missing on trip");
  AST_DCMP_SEND: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    dcmp_m && st.forward_start && !kill |=> SEND_OUT) else $error("comparison send missing");
  AST_DBLK_SEND: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    dblk_m && st.backward_start && !kill |=> SEND_OUT) else $error("blocking send missing");
  AST_PERMISSIVE_OVERREACH_MODE_TRIP: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    permissive_overreach_mode_m && !fail_i && !kill && rec_i && st.overreach_start |=> TELEPROT_TRIP)
    else $error("overreach trip missing");
  AST_DCMP_TRIP: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    dcmp_m && !kill && rec_i && st.forward_start && !fail_i |=> TELEPROT_TRIP)
    else $error("comparison trip missing");
  AST_DIRECT_UNDERREACH_MODE_TRIP: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    direct_underreach_mode_m && !kill && rec_i |=> TELEPROT_TRIP) else $error("direct trip missing");
  AST_FAIL_NO_PERM: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (permissive_overreach_mode_m || dcmp_m) && fail_i |=> !TELEPROT_TRIP) else $error("permissive trip under channel failure");
  AST_BLOCK_WINS: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    dblk_m && blocked |=> !TELEPROT_TRIP) else $error("trip while blocking received");
  AST_PERMISSIVE_UNDERREACH_MODE_QUAL: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    permissive_underreach_mode_m && !permissive_underreach_mode_cond |=> !TELEPROT_TRIP) else $error("unqualified underreach trip");
  // A long received block that has just ended must leave the prolongation running
  AST_PROLONG_ARMED: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    prolong_arm_q && !rblk_long && TIMES.block_prolong != '0 |-> blocked)
    else $error("received block not prolonged");

  COV_DIRECT_UNDERREACH_MODE: cover property (@(posedge CLK_SYS) direct_underreach_mode_m && TELEPROT_TRIP);
  COV_DBLK: cover property (@(posedge CLK_SYS) dblk_m && TELEPROT_TRIP);
  COV_PROLONG: cover property (@(posedge CLK_SYS) dblk_m && !rblk_src && pro_cnt_q != '0);
  COV_PERMISSIVE_UNDERREACH_MODE: cover property (@(posedge CLK_SYS) permissive_underreach_mode_m && TELEPROT_TRIP);
endmodule // tp_scheme_top

/* far_end_relay.sv */
// Far-end relay model: one send signal carried over two channels
`timescale 1ns/1ns
module far_end_relay (
  // Clock
  input  wire logic clk,
  // Far-end command
  input  wire logic send,
  input  wire logic lose_a,
  // Channel outputs
  output logic      rec_a,
  output logic      rec_b
);
  // A lost channel reads as the idle low of an opto input
  always_ff @(posedge clk) begin
    rec_a <= send & ~lose_a;
    rec_b <= send;
  end
endmodule // far_end_relay

/* tb_teleprotection_scheme_logic.sv */
// Testbench for the teleprotection scheme logic
`timescale 1ns/1ns
module tb_teleprotection_scheme_logic;
  import tp_scheme_pkg::*;
  logic          clk_sys  = 1'b0;
  logic          reset_n  = 1'b0;
  scheme_type    scheme   = SCHEME_OFF;
  qualifier_type qual     = QUAL_OVERREACH;
  // Two-ms settings keep the hold visible despite one tick of jitter
  times_type     times    = {14'h0002, 14'h0002, 14'h0001, 14'h0001, 14'h0002};
  logic          blk      = 1'b0;
  logic          cf       = 1'b0;
  logic          far_send = 1'b0;
  logic          lose_a   = 1'b0;
  starts_type    st       = '0;
  logic          rec_a, rec_b, trip_w, send_w, trip, send;
  logic [31:0]   seed     = 32'ha97e;
  int            n_errors = 0;
  int            checks   = 0;

  always #25 clk_sys = ~clk_sys;

  tp_scheme_top dut_u (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SCHEME_SELECT(scheme),
    .UNDERREACH_TRIP_QUALIFIER(qual), .TIMES(times), .BLOCK_IN(blk), .CHANNEL_FAILURE_IN(cf),
    .RECEIVE_A_IN(rec_a), .RECEIVE_B_IN(rec_b), .STARTS_IN(st), .TELEPROT_TRIP(trip_w), .SEND_OUT(send_w));
  far_end_relay far_u (.clk(clk_sys), .send(far_send), .lose_a(lose_a), .rec_a(rec_a), .rec_b(rec_b));

  // Outputs captured mid-cycle, so checks made at the rising edge see settled values
  always @(negedge clk_sys) begin
    trip <= trip_w;
    send <= send_w;
  end

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic exp_send(input scheme_type m, input starts_type s);
    case (m)
      PERMISSIVE_UNDERREACH_MODE: return s.underreach_start;
      DIRECT_UNDERREACH_MODE:     return s.underreach_start;
      PERMISSIVE_OVERREACH_MODE:  return s.overreach_start | s.general_trip;
      DIR_COMPARISON_MODE:        return s.forward_start | s.general_trip;
      DIR_BLOCKING_MODE:          return s.backward_start;
      default:                    return 1'b0;
    endcase
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Relay edge, four sync edges and the output edge fit in eight cycles
  task automatic settle;
    cyc(8);
  endtask

  task automatic restart;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    cyc(5);
    reset_n <= 1'b1;
  endtask

  task automatic wait_trip(input int bound, input string msg);
    for (int i = 0; i < bound && trip !== 1'b1; i++) @(posedge clk_sys);
    check(trip, 1'b1, msg);
    if (trip !== 1'b1) results;
  endtask

  task automatic no_trip(input int n, input string msg);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      if (trip !== 1'b0) seen = 1'b1;
    end
    check(seen, 1'b0, msg);
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    cyc(5);
    reset_n <= 1'b1;
    st <= '1;
    far_send <= 1'b1;
    settle;
    check(trip, 1'b0, "trip while off");
    check(send, 1'b0, "send while off");
    // Blocked, off or illegal codes must keep both outputs low
    for (int i = 0; i < 20; i++) begin
      seed = xorshift(seed);
      scheme <= scheme_type'(seed[2:0]);
      blk <= !(seed[2:0] inside {3'h0, 3'h6, 3'h7}) | seed[9];
      st <= starts_type'(seed[14:10]);
      far_send <= seed[5];
      cf <= seed[6];
      settle;
      check(trip | send, 1'b0, "output while blocked or off");
    end
    $display("test random block done");
    blk <= 1'b0;
    cf <= 1'b0;
    far_send <= 1'b0;
    for (int m = 1; m < 6; m++)
      for (int b = 0; b < 5; b++) begin
        restart;
        scheme <= scheme_type'(m);
        st <= starts_type'(5'h01 << b);
        settle;
        check(send, exp_send(scheme, st), "send source");
        if (m != 4 || b != 4) check(trip, 1'b0, "trip without receive");
      end
    $display("test send sources done");
    // Direct underreach over channel B only, channel failed
    restart;
    scheme <= DIRECT_UNDERREACH_MODE;
    cf <= 1'b1;
    lose_a <= 1'b1;
    far_send <= 1'b1;
    st <= '0;
    settle;
    check(trip, 1'b1, "direct trip on one channel");
    st.underreach_start <= 1'b1;
    settle;
    st.underreach_start <= 1'b0;
    settle;
    check(send, 1'b1, "send prolongation");
    blk <= 1'b1;
    settle;
    check(trip | send, 1'b0, "block input");
    blk <= 1'b0;
    cf <= 1'b0;
    lose_a <= 1'b0;
    $display("test direct underreach done");
    restart;
    scheme <= PERMISSIVE_OVERREACH_MODE;
    st.overreach_start <= 1'b1;
    settle;
    check(trip, 1'b1, "overreach coincidence");
    cf <= 1'b1;
    settle;
    check(trip, 1'b0, "channel failure");
    cf <= 1'b0;
    scheme <= DIR_COMPARISON_MODE;
    settle;
    check(trip, 1'b0, "comparison without forward");
    st <= 5'h10;
    settle;
    check(trip, 1'b1, "comparison with forward");
    $display("test permissive done");
    restart;
    scheme <= PERMISSIVE_UNDERREACH_MODE;
    st <= 5'h08;
    settle;
    check(trip, 1'b0, "overreach qualifier, no zone");
    qual <= QUAL_PICKUP;
    cyc(10);
    check(trip, 1'b0, "trip delay too short");
    wait_trip(41000, "pickup trip");
    qual <= QUAL_OVERREACH;
    settle;
    check(trip, 1'b0, "default qualifier");
    $display("test underreach done");
    restart;
    scheme <= DIR_BLOCKING_MODE;
    st <= 5'h10;
    no_trip(22000, "trip through block");
    cf <= 1'b1;
    wait_trip(50, "block ignored on failure");
    cf <= 1'b0;
    settle;
    no_trip(22000, "trip through block");
    far_send <= 1'b0;
    settle;
    check(trip, 1'b0, "block prolongation");
    $display("test blocking done");
    results;
  end
endmodule // tb_teleprotection_scheme_logic
